// ### rtl/omps_pkg.sv
// package of the operating mode power sequencer
// assumes a single system clock domain and synchronous reset
package omps_pkg;

  // -------------------------------------------------------------------
  // operating modes and requests
  // -------------------------------------------------------------------
  typedef enum logic [2:0] {
    OMPS_FULL_ON,
    OMPS_ACTIVE,
    OMPS_SLEEP,
    OMPS_DEEP_SLEEP,
    OMPS_HIBERNATE
  } omps_mode_t;

  // -------------------------------------------------------------------
  // widths, field values and reset values
  // -------------------------------------------------------------------
  localparam int          OMPS_RATIO_W_DEF   = 6;
  localparam logic [5:0]  OMPS_RATIO_RST     = 6'h0a;
  localparam int          OMPS_REGULATOR_FREQUENCY_FIELD_W        = 2;
  localparam logic [1:0]  OMPS_REGULATOR_FREQUENCY_FIELD_OFF      = 2'h0;
  localparam logic [1:0]  OMPS_REGULATOR_FREQUENCY_FIELD_RST      = 2'h3;
  localparam int          OMPS_SYNC_STAGES   = 2;
  localparam int          OMPS_WAKE_N        = 3;
  localparam int          OMPS_WAKE_EXT      = 0;
  localparam int          OMPS_WAKE_RTC      = 1;
  localparam int          OMPS_WAKE_CAN      = 2;

  // -------------------------------------------------------------------
  // control bundle driven to the clock and power network
  // -------------------------------------------------------------------
  typedef struct packed {
    logic loop_on;
    logic loop_bypass;
    logic core_clk_en;
    logic sys_clk_en;
    logic core_pwr_on;
  } omps_ctrl_t;

  localparam omps_ctrl_t OMPS_CTRL_RST = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};

endpackage : omps_pkg

// ### rtl/omps_clk_gate.sv
// boundary-aligned clock enable for one gated clock
// assumes i_boundary pulses in the cycle that ends a gated clock period
`timescale 1ns/10ps
module omps_clk_gate (
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  input  wire logic i_ce,
  input  wire logic i_req_en,
  input  wire logic i_boundary,
  output logic      o_en
);

  // -------------------------------------------------------------------
  // enable only moves on a boundary, so no runt pulse is produced
  // -------------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_en <= 1'b1;
    end else if (i_ce && i_boundary) begin
      o_en <= i_req_en;
    end
  end

  a_gate_on_boundary: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n)
    !(i_ce && i_boundary) |=> $stable(o_en))
    else $error("gate enable moved off a boundary");

endmodule : omps_clk_gate

// ### rtl/omps_sequencer.sv
// operating mode power sequencer: mode machine, clock and power control
// assumes the loop control and regulator fields arrive from local logic
// on this clock; wakeup pins are asynchronous
`timescale 1ns/10ps

// How it works
// - the machine holds one of five modes, each with its own settings.
// - full-on runs the loop enabled and not bypassed.
// - reset lands the machine in full-on.
// - full-on clocks the core and every enabled peripheral.
// - active bypasses the loop so clocks run at the reference rate.
// - a ratio written outside full-on waits until full-on is entered.
// - active allows dma to level-1 memory.
// - sleep stops the core clock while loop and system clock run.
// - sleep wakeup goes to active if bypass is set, else full-on.
// - sleep refuses system dma to level-1 memory.
// - deep sleep stops both clocks; rtc wakes it to active.
// - a regulator frequency write of zero in full-on or active enters hibernate.
// - can, rtc or reset leave hibernate; rtc starts a reset sequence.
module omps_sequencer #(
  parameter int RATIO_W  = omps_pkg::OMPS_RATIO_W_DEF,
  parameter int PERIPH_N = 8
) (
  input  wire logic                        i_sys_clk,
  input  wire logic                        i_rst_n,
  input  wire logic                        i_ce,
  input  wire logic                        i_req_valid,
  input  wire omps_pkg::omps_mode_t        i_req_mode,
  input  wire logic                        i_loop_enable,
  input  wire logic                        i_bypass,
  input  wire logic                        i_ratio_wr,
  input  wire logic [RATIO_W-1:0]          i_ratio,
  input  wire logic                        i_regulator_frequency_field_wr,
  input  wire logic [omps_pkg::OMPS_REGULATOR_FREQUENCY_FIELD_W-1:0] i_regulator_frequency_field,
  input  wire logic                        i_ext_wake,
  input  wire logic                        i_rtc_wake,
  input  wire logic                        i_can_wake,
  input  wire logic                        i_core_boundary,
  input  wire logic                        i_sys_boundary,
  input  wire logic [PERIPH_N-1:0]         i_periph_en,
  output omps_pkg::omps_mode_t             o_mode,
  output omps_pkg::omps_ctrl_t             o_ctrl,
  output logic [RATIO_W-1:0]               o_ratio,
  output logic [PERIPH_N-1:0]              o_periph_clk_en,
  output logic                             o_dma_l1_allow,
  output logic                             o_hw_reset_seq
);
  import omps_pkg::*;

  // -------------------------------------------------------------------
  // elaboration checks
  // -------------------------------------------------------------------
  if (RATIO_W < 4 || RATIO_W > 6 || PERIPH_N < 1) begin : g_bad_param
    $error("RATIO_W must lie in 4..6 and PERIPH_N be at least 1");
  end

  // -------------------------------------------------------------------
  // wakeup synchronisers
  // -------------------------------------------------------------------
  logic [OMPS_WAKE_N-1:0] wake_meta_r;
  logic [OMPS_WAKE_N-1:0] wake_r;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      wake_meta_r <= '0;
      wake_r      <= '0;
    end else if (i_ce) begin
      wake_meta_r <= {i_can_wake, i_rtc_wake, i_ext_wake};
      wake_r      <= wake_meta_r;
    end
  end

  // -------------------------------------------------------------------
  // mode machine
  // -------------------------------------------------------------------
  omps_mode_t mode_r;
  omps_mode_t mode_nxt;
  logic       loop_req_ok;
  logic       hib_req;
  logic       rst_seq_nxt;

  assign loop_req_ok = i_loop_enable;
  assign hib_req     = i_regulator_frequency_field_wr && (i_regulator_frequency_field == OMPS_REGULATOR_FREQUENCY_FIELD_OFF);

  always_comb begin
    mode_nxt    = mode_r;
    rst_seq_nxt = 1'b0;
    case (mode_r)
      OMPS_FULL_ON, OMPS_ACTIVE: begin
        if (hib_req) begin
          mode_nxt = OMPS_HIBERNATE;
        end else if (i_req_valid) begin
          case (i_req_mode)
            OMPS_FULL_ON, OMPS_SLEEP: begin
              // loop must be running first
              if (loop_req_ok) begin
                mode_nxt = i_req_mode;
              end
            end
            OMPS_ACTIVE:     mode_nxt = OMPS_ACTIVE;
            OMPS_DEEP_SLEEP: mode_nxt = OMPS_DEEP_SLEEP;
            default:         mode_nxt = mode_r;
          endcase
        end
      end
      OMPS_SLEEP: begin
        if (wake_r[OMPS_WAKE_EXT] || wake_r[OMPS_WAKE_RTC]) begin
          mode_nxt = i_bypass ? OMPS_ACTIVE : OMPS_FULL_ON;
        end
      end
      OMPS_DEEP_SLEEP: begin
        if (wake_r[OMPS_WAKE_RTC]) begin
          mode_nxt = OMPS_ACTIVE;
        end
      end
      OMPS_HIBERNATE: begin
        rst_seq_nxt = wake_r[OMPS_WAKE_RTC];
        if (wake_r[OMPS_WAKE_RTC] || wake_r[OMPS_WAKE_CAN]) begin
          mode_nxt = OMPS_FULL_ON;
        end
      end
      default: mode_nxt = OMPS_FULL_ON;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      mode_r         <= OMPS_FULL_ON;
      o_hw_reset_seq <= 1'b0;
    end else if (i_ce) begin
      mode_r         <= mode_nxt;
      o_hw_reset_seq <= rst_seq_nxt;
    end
  end

  // -------------------------------------------------------------------
  // multiplier ratio: pending copy, applied on full-on entry
  // -------------------------------------------------------------------
  logic [RATIO_W-1:0] ratio_pend_r;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      ratio_pend_r <= OMPS_RATIO_RST[RATIO_W-1:0];
    end else if (i_ce && i_ratio_wr) begin
      ratio_pend_r <= i_ratio;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_ratio <= OMPS_RATIO_RST[RATIO_W-1:0];
    end else if (i_ce && mode_r == OMPS_FULL_ON && i_ratio_wr) begin
      o_ratio <= i_ratio;
    end else if (i_ce && mode_r != OMPS_FULL_ON
                 && mode_nxt == OMPS_FULL_ON) begin
      // last write wins if it lands in the entry cycle
      o_ratio <= i_ratio_wr ? i_ratio : ratio_pend_r;
    end
  end

  // -------------------------------------------------------------------
  // per-mode settings
  // -------------------------------------------------------------------
  omps_ctrl_t ctrl_req;

  always_comb begin
    ctrl_req = '0;
    case (mode_r)
      OMPS_FULL_ON: ctrl_req = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
      OMPS_ACTIVE:  ctrl_req = '{i_loop_enable, 1'b1, 1'b1, 1'b1, 1'b1};
      OMPS_SLEEP:   ctrl_req = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
      OMPS_DEEP_SLEEP: ctrl_req = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
      OMPS_HIBERNATE:  ctrl_req = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
      default:      ctrl_req = OMPS_CTRL_RST;
    endcase
  end

  // loop_on, loop_bypass, core_pwr_on; the gates own the clock enables
  logic [2:0] ctrl_r;
  logic       core_en;
  logic       sys_en;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      ctrl_r <= {OMPS_CTRL_RST.loop_on, OMPS_CTRL_RST.loop_bypass,
                 OMPS_CTRL_RST.core_pwr_on};
    end else if (i_ce) begin
      ctrl_r <= {ctrl_req.loop_on, ctrl_req.loop_bypass,
                 ctrl_req.core_pwr_on};
    end
  end

  // -------------------------------------------------------------------
  // glitch-free clock enables
  // -------------------------------------------------------------------
  omps_clk_gate u_core_gate (
    .i_sys_clk  (i_sys_clk),
    .i_rst_n    (i_rst_n),
    .i_ce       (i_ce),
    .i_req_en   (ctrl_req.core_clk_en),
    .i_boundary (i_core_boundary),
    .o_en       (core_en)
  );

  omps_clk_gate u_sys_gate (
    .i_sys_clk  (i_sys_clk),
    .i_rst_n    (i_rst_n),
    .i_ce       (i_ce),
    .i_req_en   (ctrl_req.sys_clk_en),
    .i_boundary (i_sys_boundary),
    .o_en       (sys_en)
  );

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_periph_clk_en <= '0;
    end else if (i_ce && i_sys_boundary) begin
      o_periph_clk_en <= i_periph_en & {PERIPH_N{ctrl_req.sys_clk_en}};
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_dma_l1_allow <= 1'b1;
    end else if (i_ce) begin
      o_dma_l1_allow <= (mode_nxt == OMPS_FULL_ON)
                     || (mode_nxt == OMPS_ACTIVE);
    end
  end

  assign o_mode = mode_r;
  assign o_ctrl = '{ctrl_r[2], ctrl_r[1], core_en, sys_en, ctrl_r[0]};

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  a_reset_full_on: assert property (@(posedge i_sys_clk)
    $rose(i_rst_n) |-> mode_r == OMPS_FULL_ON)
    else $error("not in full-on after reset");
  a_sleep_wake_dir: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n)
    (i_ce && mode_r == OMPS_SLEEP && wake_r[OMPS_WAKE_EXT])
    |=> mode_r == ($past(i_bypass) ? OMPS_ACTIVE : OMPS_FULL_ON))
    else $error("sleep wakeup took wrong mode");
  a_deep_rtc_act: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n)
    (i_ce && mode_r == OMPS_DEEP_SLEEP && wake_r[OMPS_WAKE_RTC])
    |=> mode_r == OMPS_ACTIVE)
    else $error("deep sleep rtc wake not to active");
  a_hib_entry: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n)
    (i_ce && mode_r == OMPS_FULL_ON && hib_req)
    |=> mode_r == OMPS_HIBERNATE ##1 !o_ctrl.core_pwr_on)
    else $error("regulator off did not enter hibernate");
  a_hib_rtc_reset: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n)
    (i_ce && mode_r == OMPS_HIBERNATE && wake_r[OMPS_WAKE_RTC])
    |=> o_hw_reset_seq && mode_r == OMPS_FULL_ON)
    else $error("rtc wake from hibernate without reset sequence");
  a_loop_refuse: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n)
    (i_ce && mode_r == OMPS_ACTIVE && !hib_req && i_req_valid
     && i_req_mode == OMPS_SLEEP && !i_loop_enable)
    |=> mode_r == OMPS_ACTIVE)
    else $error("sleep entered with loop disabled");
  a_ratio_pending: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n)
    (i_ce && mode_r == OMPS_ACTIVE && i_ratio_wr && mode_nxt == OMPS_ACTIVE)
    |=> $stable(o_ratio))
    else $error("ratio applied outside full-on");
  a_full_on_ctrl: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n)
    (i_ce && mode_r == OMPS_FULL_ON && mode_nxt == OMPS_FULL_ON) ##1 i_ce
    |=> o_ctrl.loop_on && !o_ctrl.loop_bypass)
    else $error("full-on loop setting wrong");
  a_active_bypass: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n)
    (i_ce && mode_r == OMPS_ACTIVE) |=> o_ctrl.loop_bypass)
    else $error("active mode not bypassed");
  a_sleep_no_dma: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n)
    (i_ce && mode_nxt == OMPS_SLEEP) |=> !o_dma_l1_allow)
    else $error("dma allowed in sleep");
  a_sleep_sys_run: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n)
    (mode_r == OMPS_SLEEP && i_ce && i_sys_boundary && i_core_boundary)
    |=> o_ctrl.sys_clk_en && !o_ctrl.core_clk_en)
    else $error("sleep clock settings wrong");
  a_periph_gated: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n)
    (i_ce && i_sys_boundary && mode_r == OMPS_FULL_ON)
    |=> o_periph_clk_en == $past(i_periph_en))
    else $error("enabled peripheral not clocked in full-on");

endmodule : omps_sequencer

// ### tb/omps_sequencer_test.sv
// testbench of the operating mode power sequencer, with a mode model
// assumes rtl/omps_pkg.sv and the rtl modules are compiled before it
`timescale 1ns/10ps
module omps_sequencer_test;
  import omps_pkg::*;
  // ------------------------------------------------------------------
  // signals and model state
  // ------------------------------------------------------------------
  logic       i_sys_clk, i_rst_n, i_ce, i_req_valid, i_loop_enable;
  logic       i_bypass, i_ratio_wr, i_regulator_frequency_field_wr, i_ext_wake, i_rtc_wake;
  logic       i_can_wake, i_core_boundary, i_sys_boundary;
  logic       o_dma_l1_allow, o_hw_reset_seq, prev_core, prev_sys;
  logic       cb, sb, rs;
  omps_mode_t i_req_mode, o_mode, exp_mode;
  omps_ctrl_t o_ctrl;
  logic [5:0] i_ratio, o_ratio, exp_ratio, pend;
  logic [1:0] i_regulator_frequency_field;
  logic [7:0] i_periph_en, o_periph_clk_en;
  int         error_cnt, checks, seed, cyc, k;

  omps_sequencer #(.RATIO_W(6), .PERIPH_N(8)) u_omps_sequencer (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
    .i_req_valid(i_req_valid), .i_req_mode(i_req_mode),
    .i_loop_enable(i_loop_enable), .i_bypass(i_bypass),
    .i_ratio_wr(i_ratio_wr), .i_ratio(i_ratio), .i_regulator_frequency_field_wr(i_regulator_frequency_field_wr),
    .i_regulator_frequency_field(i_regulator_frequency_field), .i_ext_wake(i_ext_wake), .i_rtc_wake(i_rtc_wake),
    .i_can_wake(i_can_wake), .i_core_boundary(i_core_boundary),
    .i_sys_boundary(i_sys_boundary), .i_periph_en(i_periph_en),
    .o_mode(o_mode), .o_ctrl(o_ctrl), .o_ratio(o_ratio),
    .o_periph_clk_en(o_periph_clk_en), .o_dma_l1_allow(o_dma_l1_allow),
    .o_hw_reset_seq(o_hw_reset_seq));

  // ------------------------------------------------------------------
  // clock, boundary pulses, gating monitor
  // ------------------------------------------------------------------
  initial begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end

  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    i_core_boundary <= (cyc % 3 == 2);
    i_sys_boundary <= (cyc % 4 == 3);
    if (rs === 1'b1) begin
      chk(16'(prev_core !== o_ctrl.core_clk_en && !cb), 16'h0);
      chk(16'(prev_sys !== o_ctrl.sys_clk_en && !sb), 16'h0);
    end
    prev_core <= o_ctrl.core_clk_en;
    prev_sys <= o_ctrl.sys_clk_en;
    cb <= i_core_boundary;
    sb <= i_sys_boundary;
    rs <= i_rst_n;
  end

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic stop_test;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test

  // settle, then compare mode, dma allow, control and full-on peripheral enables with the model
  task automatic chk_state;
    repeat (12) @(posedge i_sys_clk);
    #1;
    chk(16'(o_mode), 16'(exp_mode));
    chk(16'(o_dma_l1_allow),
        16'(exp_mode inside {OMPS_FULL_ON, OMPS_ACTIVE}));
    case (exp_mode)
      OMPS_FULL_ON: begin
        chk(16'(o_ctrl), 16'h17);
        chk(16'(o_periph_clk_en), 16'(i_periph_en));
      end
      OMPS_ACTIVE: chk(16'(o_ctrl), 16'({i_loop_enable, 4'hf}));
      OMPS_SLEEP: chk(16'(5'(o_ctrl) & 5'h17), 16'h13);
      OMPS_DEEP_SLEEP: chk(16'(5'(o_ctrl) & 5'h17), 16'h01);
      default: chk(16'(5'(o_ctrl) & 5'h17), 16'h00);
    endcase
  endtask : chk_state

  task automatic do_reset;
    @(posedge i_sys_clk) i_rst_n <= 1'b0;
    repeat (8) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    exp_mode = OMPS_FULL_ON;
    exp_ratio = OMPS_RATIO_RST;
    pend = OMPS_RATIO_RST;
    #1;
    chk(16'(o_mode), 16'(exp_mode));
    chk(16'(o_ctrl), 16'(OMPS_CTRL_RST));
    chk(16'(o_ratio), 16'(exp_ratio));
    chk(16'({o_dma_l1_allow, o_hw_reset_seq}), 16'h2);
  endtask : do_reset

  task automatic req(input omps_mode_t m);
    @(posedge i_sys_clk) i_req_valid <= 1'b1;
    i_req_mode <= m;
    @(posedge i_sys_clk) i_req_valid <= 1'b0;
    if (i_ce && exp_mode inside {OMPS_FULL_ON, OMPS_ACTIVE}
        && m != OMPS_HIBERNATE
        && !(m inside {OMPS_FULL_ON, OMPS_SLEEP} && !i_loop_enable)) begin
      if (m == OMPS_FULL_ON && exp_mode != OMPS_FULL_ON)
        exp_ratio = pend;
      exp_mode = m;
    end
    #1;
    chk(16'(o_mode), 16'(exp_mode));
    chk(16'(o_ratio), 16'(exp_ratio));
    chk_state;
  endtask : req

  task automatic wr(input logic [5:0] r);
    @(posedge i_sys_clk) i_ratio_wr <= 1'b1;
    i_ratio <= r;
    @(posedge i_sys_clk) i_ratio_wr <= 1'b0;
    pend = r;
    if (exp_mode == OMPS_FULL_ON)
      exp_ratio = r;
    #1 chk(16'(o_ratio), 16'(exp_ratio));
  endtask : wr

  task automatic wake(input int src);
    omps_mode_t was;
    logic       pulse;
    int         n;
    was = exp_mode;
    pulse = 1'b0;
    n = 0;
    case (exp_mode)
      OMPS_SLEEP: if (src != OMPS_WAKE_CAN)
        exp_mode = i_bypass ? OMPS_ACTIVE : OMPS_FULL_ON;
      OMPS_DEEP_SLEEP: if (src == OMPS_WAKE_RTC) exp_mode = OMPS_ACTIVE;
      OMPS_HIBERNATE: if (src != OMPS_WAKE_EXT) begin
        exp_mode = OMPS_FULL_ON;
        pulse = (src == OMPS_WAKE_RTC);
      end
      default: ;
    endcase
    if (exp_mode == OMPS_FULL_ON && was != OMPS_FULL_ON)
      exp_ratio = pend;
    @(posedge i_sys_clk) {i_can_wake, i_rtc_wake, i_ext_wake} <= 3'(1) << src;
    do begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end while (o_mode === was && n < 8);
    chk(16'(o_mode), 16'(exp_mode));
    chk(16'(o_hw_reset_seq), 16'(pulse));
    @(posedge i_sys_clk) {i_can_wake, i_rtc_wake, i_ext_wake} <= 3'h0;
    #1 chk(16'(o_hw_reset_seq), 16'h0);
    chk_state;
  endtask : wake

  task automatic regulator_frequency_field(input logic [1:0] v);
    @(posedge i_sys_clk) i_regulator_frequency_field_wr <= 1'b1;
    i_regulator_frequency_field <= v;
    @(posedge i_sys_clk) i_regulator_frequency_field_wr <= 1'b0;
    if (v == OMPS_REGULATOR_FREQUENCY_FIELD_OFF && exp_mode inside {OMPS_FULL_ON, OMPS_ACTIVE})
      exp_mode = OMPS_HIBERNATE;
    #1 chk(16'(o_mode), 16'(exp_mode));
    chk_state;
  endtask : regulator_frequency_field

  // ------------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------------
  initial begin
    seed = 32'h5078;
    {i_rst_n, i_req_valid, i_ratio_wr, i_regulator_frequency_field_wr, i_bypass} = 5'h0;
    {i_ext_wake, i_rtc_wake, i_can_wake, rs} = 4'h0;
    {i_core_boundary, i_sys_boundary, i_ce, i_loop_enable} = 4'h3;
    i_req_mode = OMPS_FULL_ON;
    {i_ratio, i_regulator_frequency_field} = '0;
    cyc = 0;
    i_periph_en = 8'($random(seed));
    do_reset;
    wr(6'($random(seed)));
    req(OMPS_ACTIVE);
    wr(6'($random(seed)));
    req(OMPS_FULL_ON);
    req(OMPS_ACTIVE);
    @(posedge i_sys_clk) i_loop_enable <= 1'b0;
    req(OMPS_FULL_ON);
    req(OMPS_SLEEP);
    @(posedge i_sys_clk) i_loop_enable <= 1'b1;
    i_bypass <= 1'b1;
    req(OMPS_SLEEP);
    req(OMPS_FULL_ON);
    wake(OMPS_WAKE_EXT);
    @(posedge i_sys_clk) i_bypass <= 1'b0;
    i_periph_en <= 8'($random(seed));
    req(OMPS_SLEEP);
    wake(OMPS_WAKE_RTC);
    req(OMPS_DEEP_SLEEP);
    wake(OMPS_WAKE_EXT);
    wake(OMPS_WAKE_CAN);
    wake(OMPS_WAKE_RTC);
    regulator_frequency_field(2'h2);
    regulator_frequency_field(OMPS_REGULATOR_FREQUENCY_FIELD_OFF);
    req(OMPS_FULL_ON);
    wake(OMPS_WAKE_EXT);
    wake(OMPS_WAKE_RTC);
    regulator_frequency_field(OMPS_REGULATOR_FREQUENCY_FIELD_OFF);
    wake(OMPS_WAKE_CAN);
    // clock enable low: a request must not move anything
    @(posedge i_sys_clk) i_ce <= 1'b0;
    req(OMPS_SLEEP);
    @(posedge i_sys_clk) i_ce <= 1'b1;
    req(OMPS_ACTIVE);
    regulator_frequency_field(OMPS_REGULATOR_FREQUENCY_FIELD_OFF);
    do_reset;
    repeat (16) begin
      k = {$random(seed)} % 4;
      if (k == 0)
        wr(6'($random(seed)));
      else if (k == 1)
        wake({$random(seed)} % 3);
      else
        req(omps_mode_t'({$random(seed)} % 4));
    end
    stop_test;
  end

  initial begin
    repeat (20000) @(posedge i_sys_clk);
    error_cnt++;
    $display("mismatch at %0t: run did not finish", $time);
    stop_test;
  end
endmodule : omps_sequencer_test
